/* File: acr_ctrl_status.sv */
// accel control and status register bank with interrupt pin routing
`timescale 1ns/10ps
`default_nettype none
`include "acr_regs.svh"

module acr_ctrl_status
    import acr_pkg::*;
(
    input  wire logic       CLOCK,          // 20 MHz
    input  wire logic       RSTN,           // sync reset, low
    input  wire acr_addr_t  REG_ADDR,       // register address from serial engine
    input  wire logic       REG_WR,         // write strobe
    input  wire acr_byte_t  REG_WDATA,      // write data
    input  wire logic       REG_RD,         // read strobe
    output logic            REG_RVALID,     // read data valid
    output acr_byte_t       REG_RDATA,      // read data
    input  wire logic [2:0] SAMPLE_STB,     // z,y,x fresh sample
    input  wire logic       SET_STB,        // complete xyz set
    input  wire logic       TAP_IRQ,        // tap detect request
    input  wire logic       GEN1_IRQ,       // generator one request
    input  wire logic       GEN2_IRQ,       // generator two request
    input  wire logic       READY1_IRQ,     // data ready one
    input  wire logic       READY2_IRQ,     // data ready two
    input  wire logic       WTM_IRQ,        // fifo watermark
    input  wire logic       FIFO_OVR_IRQ,   // fifo overrun
    input  wire logic       ACTIVITY,       // active function status
    input  wire logic       SIX_DIR_GEN1,   // gen one six-direction bit
    input  wire logic       SIX_DIR_GEN2,   // gen two six-direction bit
    input  wire logic       RELOAD_DONE,    // memory reload finished
    output logic [1:0]      HP_MODE,        // filter mode
    output logic [1:0]      HP_CUTOFF,      // cutoff select
    output logic            HP_OUT_SEL,     // filtered to outputs and fifo
    output logic            HP_TAP,         // filtered to tap detect
    output logic            HP_GEN1,        // filtered to gen one
    output logic            HP_GEN2,        // filtered to gen two
    output logic            FILTER_RESET,   // filter reset pulse
    output logic [2:0]      AXIS_HOLD,      // z,y,x output pair frozen
    output logic            BYTE_ORDER,     // 1: high byte at low address
    output logic [1:0]      RANGE,          // full scale
    output logic            HIGH_RES,       // high resolution
    output logic            SPI_3WIRE,      // 1: three-wire spi
    output logic            RELOAD_REQ,     // reload internal memory
    output logic            FIFO_ENABLE,    // fifo on
    output logic            FOUR_DIR_GEN1,  // gen one four-direction
    output logic            FOUR_DIR_GEN2,  // gen two four-direction
    output acr_byte_t       REFERENCE,      // reference value
    output logic            GEN1_ACTIVE,    // gen one active flag
    output logic            GEN2_ACTIVE,    // gen two active flag
    output logic            GEN1_SRC_CLR,   // gen one source read pulse
    output logic            GEN2_SRC_CLR,   // gen two source read pulse
    output logic            IRQ_PIN_A,      // interrupt pin a
    output logic            IRQ_PIN_B       // interrupt pin b
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input acr_addr_t a, input acr_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // every axis still flagged is read in full this cycle
    function automatic logic set_read(input logic [2:0] done, input logic [2:0] pend);
        set_read = &(done | ~pend);
    endfunction

    acr_byte_t filt_r;
    acr_byte_t pina_r;
    acr_byte_t fmt_r;
    acr_byte_t boot_r;
    acr_byte_t pinb_r;
    acr_byte_t ref_r;
    logic [3:0] da_r;
    logic [3:0] or_r;
    logic [2:0] rd_lo_r;
    logic [2:0] rd_hi_r;
    logic [2:0] lo_hit;
    logic [2:0] hi_hit;
    logic [2:0] axis_done;
    logic       gen1_r;
    logic       gen2_r;
    logic       irq_seen_r;
    logic       rd_gen1;
    logic       rd_gen2;
    logic       pin_a_nxt;
    logic       pin_b_nxt;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            lo_hit[i] = REG_RD & hit(REG_ADDR, `ACR_OFS_OUTX_LO + 7'(2 * i));
            hi_hit[i] = REG_RD & hit(REG_ADDR, `ACR_OFS_OUTX_LO + 7'(2 * i + 1));
            axis_done[i] = (rd_lo_r[i] | lo_hit[i]) & (rd_hi_r[i] | hi_hit[i]);
        end
    end

    assign rd_gen1 = REG_RD & hit(REG_ADDR, `ACR_OFS_GEN1SRC);
    assign rd_gen2 = REG_RD & hit(REG_ADDR, `ACR_OFS_GEN2SRC);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            filt_r <= `ACR_RST_BYTE;
            pina_r <= `ACR_RST_BYTE;
            fmt_r  <= `ACR_RST_BYTE;
            pinb_r <= `ACR_RST_BYTE;
            ref_r  <= `ACR_RST_BYTE;
        end else if (REG_WR) begin
            if (hit(REG_ADDR, `ACR_OFS_FILT))
                filt_r <= REG_WDATA;
            if (hit(REG_ADDR, `ACR_OFS_PINA))
                pina_r <= REG_WDATA & `ACR_MSK_PINA;
            // reserved format bits are dropped; host keeps them zero anyway
            if (hit(REG_ADDR, `ACR_OFS_FMT))
                fmt_r <= REG_WDATA & `ACR_MSK_FMT;
            if (hit(REG_ADDR, `ACR_OFS_PINB))
                pinb_r <= REG_WDATA & `ACR_MSK_PINB;
            if (hit(REG_ADDR, `ACR_OFS_REF))
                ref_r <= REG_WDATA;
        end
    end

    // reboot bit: written 1 stays until reload reports done
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            boot_r <= `ACR_RST_BYTE;
        end else begin
            if (REG_WR && hit(REG_ADDR, `ACR_OFS_BOOT))
                boot_r <= REG_WDATA & `ACR_MSK_BOOT;
            else if (RELOAD_DONE)
                boot_r[`ACR_BIT_REBOOT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axis status flags
    // ------------------------------------------------------------
    // a flag set in the same cycle as its clear stays set
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            da_r    <= 4'h0;
            or_r    <= 4'h0;
            rd_lo_r <= 3'h0;
            rd_hi_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (SAMPLE_STB[i]) begin
                    da_r[i]    <= 1'b1;
                    or_r[i]    <= da_r[i] & ~axis_done[i];
                    rd_lo_r[i] <= 1'b0;
                    rd_hi_r[i] <= 1'b0;
                end else if (axis_done[i]) begin
                    da_r[i]    <= 1'b0;
                    rd_lo_r[i] <= 1'b0;
                    rd_hi_r[i] <= 1'b0;
                end else begin
                    rd_lo_r[i] <= rd_lo_r[i] | lo_hit[i];
                    rd_hi_r[i] <= rd_hi_r[i] | hi_hit[i];
                end
            end
            if (SET_STB) begin
                da_r[3] <= 1'b1;
                or_r[3] <= da_r[3] & ~set_read(axis_done, da_r[2:0]);
            end else if (da_r[3] && set_read(axis_done, da_r[2:0])) begin
                da_r[3] <= 1'b0;
            end
        end
    end

    // block update: pair frozen once one byte is read, until the other is
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            AXIS_HOLD <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++)
                AXIS_HOLD[i] <= fmt_r[`ACR_BIT_BDU] & ~axis_done[i]
                              & (rd_lo_r[i] | rd_hi_r[i] | lo_hit[i] | hi_hit[i]);
        end
    end

    // ------------------------------------------------------------
    // generator active flags
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            gen1_r <= 1'b0;
            gen2_r <= 1'b0;
        end else begin
            if (GEN1_IRQ)
                gen1_r <= 1'b1;
            else if (!boot_r[`ACR_BIT_LATCH1] || rd_gen1)
                gen1_r <= 1'b0;
            if (GEN2_IRQ)
                gen2_r <= 1'b1;
            else if (!boot_r[`ACR_BIT_LATCH2] || rd_gen2)
                gen2_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // filter reset
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            irq_seen_r   <= 1'b0;
            FILTER_RESET <= 1'b0;
        end else begin
            irq_seen_r   <= GEN1_IRQ | GEN2_IRQ;
            // reset on reference read in mode 00, on a new event in mode 11
            FILTER_RESET <= (acr_hpm_e'(filt_r[7:6]) == ACR_HPM_RESET_ON_REF
                             && REG_RD && hit(REG_ADDR, `ACR_OFS_REF))
                          | (acr_hpm_e'(filt_r[7:6]) == ACR_HPM_AUTORESET
                             && (GEN1_IRQ | GEN2_IRQ) && !irq_seen_r);
        end
    end

    // ------------------------------------------------------------
    // interrupt pins
    // ------------------------------------------------------------
    always_comb begin
        pin_a_nxt = |(pina_r[7:1] & {TAP_IRQ, gen1_r, gen2_r, READY1_IRQ,
                                     READY2_IRQ, WTM_IRQ, FIFO_OVR_IRQ});
        pin_b_nxt = |(pinb_r[7:3] & {TAP_IRQ, gen1_r, gen2_r,
                                     boot_r[`ACR_BIT_REBOOT], ACTIVITY});
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            IRQ_PIN_A <= 1'b0;
            IRQ_PIN_B <= 1'b0;
        end else begin
            IRQ_PIN_A <= pin_a_nxt ^ pinb_r[`ACR_BIT_POL];
            IRQ_PIN_B <= pin_b_nxt ^ pinb_r[`ACR_BIT_POL];
        end
    end

    // ------------------------------------------------------------
    // read port and source-read pulses
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            REG_RVALID   <= 1'b0;
            REG_RDATA    <= `ACR_RST_BYTE;
            GEN1_SRC_CLR <= 1'b0;
            GEN2_SRC_CLR <= 1'b0;
        end else begin
            REG_RVALID   <= REG_RD;
            GEN1_SRC_CLR <= rd_gen1;
            GEN2_SRC_CLR <= rd_gen2;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    `ACR_OFS_FILT: REG_RDATA <= filt_r;
                    `ACR_OFS_PINA: REG_RDATA <= pina_r;
                    `ACR_OFS_FMT:  REG_RDATA <= fmt_r;
                    `ACR_OFS_BOOT: REG_RDATA <= boot_r;
                    `ACR_OFS_PINB: REG_RDATA <= pinb_r;
                    `ACR_OFS_REF:  REG_RDATA <= ref_r;
                    `ACR_OFS_STAT: REG_RDATA <= {or_r[3], or_r[2:0], da_r[3], da_r[2:0]};
                    default:       REG_RDATA <= `ACR_RST_BYTE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            HP_MODE       <= 2'h0;
            HP_CUTOFF     <= 2'h0;
            HP_OUT_SEL    <= 1'b0;
            HP_TAP        <= 1'b0;
            HP_GEN1       <= 1'b0;
            HP_GEN2       <= 1'b0;
            BYTE_ORDER    <= 1'b0;
            RANGE         <= 2'h0;
            HIGH_RES      <= 1'b0;
            SPI_3WIRE     <= 1'b0;
            RELOAD_REQ    <= 1'b0;
            FIFO_ENABLE   <= 1'b0;
            FOUR_DIR_GEN1 <= 1'b0;
            FOUR_DIR_GEN2 <= 1'b0;
            REFERENCE     <= `ACR_RST_BYTE;
            GEN1_ACTIVE   <= 1'b0;
            GEN2_ACTIVE   <= 1'b0;
        end else begin
            HP_MODE       <= filt_r[7:6];
            HP_CUTOFF     <= filt_r[5:4];
            HP_OUT_SEL    <= filt_r[`ACR_BIT_FDS];
            HP_TAP        <= filt_r[`ACR_BIT_HPTAP];
            HP_GEN1       <= filt_r[`ACR_BIT_HPG1];
            HP_GEN2       <= filt_r[`ACR_BIT_HPG2];
            BYTE_ORDER    <= fmt_r[`ACR_BIT_BLE];
            RANGE         <= fmt_r[5:4];
            HIGH_RES      <= fmt_r[`ACR_BIT_HR];
            SPI_3WIRE     <= fmt_r[`ACR_BIT_SIM];
            RELOAD_REQ    <= boot_r[`ACR_BIT_REBOOT];
            FIFO_ENABLE   <= boot_r[`ACR_BIT_FIFOEN];
            FOUR_DIR_GEN1 <= boot_r[`ACR_BIT_FOURD1] & SIX_DIR_GEN1;
            FOUR_DIR_GEN2 <= boot_r[`ACR_BIT_FOURD2] & SIX_DIR_GEN2;
            REFERENCE     <= ref_r;
            GEN1_ACTIVE   <= gen1_r;
            GEN2_ACTIVE   <= gen2_r;
        end
    end

endmodule
`default_nettype wire

/* File: acr_ctrl_status_assertions.sv */
// port assertions for the accel control and status bank
`timescale 1ns/10ps
`default_nettype none
module acr_ctrl_status_chk
    import acr_pkg::*;
(
    input wire logic       CLOCK,        // clock
    input wire logic       RSTN,         // reset
    input wire acr_addr_t  REG_ADDR,     // address
    input wire logic       REG_WR,       // write
    input wire acr_byte_t  REG_WDATA,    // wdata
    input wire logic       REG_RD,       // read
    input wire logic       REG_RVALID,   // answer
    input wire logic       GEN1_IRQ,     // gen one
    input wire logic       GEN2_IRQ,     // gen two
    input wire logic       RELOAD_DONE,  // reload end
    input wire logic [1:0] HP_MODE,      // mode
    input wire logic [1:0] HP_CUTOFF,    // cutoff
    input wire logic       HP_OUT_SEL,   // filtered out
    input wire logic       HP_TAP,       // tap path
    input wire logic       HP_GEN1,      // gen one path
    input wire logic       HP_GEN2,      // gen two path
    input wire logic       FILTER_RESET, // reset pulse
    input wire logic       BYTE_ORDER,   // order
    input wire logic [1:0] RANGE,        // scale
    input wire logic       HIGH_RES,     // hi res
    input wire logic       SPI_3WIRE,    // wires
    input wire logic       RELOAD_REQ,   // reload
    input wire acr_byte_t  REFERENCE,    // reference
    input wire logic       GEN1_ACTIVE,  // active
    input wire logic       GEN1_SRC_CLR, // src read
    input wire logic       GEN2_SRC_CLR  // src two read
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    sequence s_wr(acr_addr_t a); REG_WR && REG_ADDR == a; endsequence
    sequence s_rd(acr_addr_t a); REG_RD && REG_ADDR == a; endsequence
    // a generator request rising after a quiet cycle
    sequence s_rise; (GEN1_IRQ || GEN2_IRQ) && !$past(GEN1_IRQ) && !$past(GEN2_IRQ); endsequence
    property p_rvalid; REG_RVALID == $past(REG_RD); endproperty
    property p_filt; s_wr(7'h21) |-> ##2
        {HP_MODE, HP_CUTOFF, HP_OUT_SEL, HP_TAP, HP_GEN2, HP_GEN1} == $past(REG_WDATA, 2);
    endproperty
    property p_fmt; s_wr(7'h23) |-> ##2
        {BYTE_ORDER, RANGE, HIGH_RES, SPI_3WIRE} == {$past(REG_WDATA[6:3], 2), $past(REG_WDATA[0], 2)};
    endproperty
    property p_ref; s_wr(7'h26) |-> ##2 REFERENCE == $past(REG_WDATA, 2); endproperty
    property p_reload; s_wr(7'h24) ##0 (REG_WDATA[7] && !RELOAD_DONE) |-> ##[1:2] RELOAD_REQ;
    endproperty
    // back-to-back source reads legally stretch the pulse, so the end is checked after a gap
    property p_src_clr; s_rd(7'h31) ##1 !REG_RD |-> GEN1_SRC_CLR ##1 !GEN1_SRC_CLR;
    endproperty
    property p_src_clr2; s_rd(7'h35) ##1 !REG_RD |-> GEN2_SRC_CLR ##1 !GEN2_SRC_CLR;
    endproperty
    property p_gen1; GEN1_IRQ |-> ##[1:2] GEN1_ACTIVE; endproperty
    // mode output lags the register by one cycle, so it is looked at one cycle on
    property p_freset; s_rd(7'h26) ##1 HP_MODE == 2'b00 |-> FILTER_RESET; endproperty
    property p_fauto; s_rise ##1 HP_MODE == 2'b11 |-> FILTER_RESET; endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read answer late");
    a_filt: assert property (p_filt)
        else $error("filter config wrong");
    a_fmt: assert property (p_fmt)
        else $error("format config wrong");
    a_ref: assert property (p_ref)
        else $error("reference wrong");
    a_reload: assert property (p_reload)
        else $error("reload not requested");
    a_src_clr: assert property (p_src_clr)
        else $error("source clear pulse wrong");
    a_gen1: assert property (p_gen1)
        else $error("gen one flag missing");
    a_freset: assert property (p_freset)
        else $error("filter reset missing");
    a_src_clr2: assert property (p_src_clr2)
        else $error("source two clear pulse wrong");
    a_fauto: assert property (p_fauto)
        else $error("filter auto reset missing");
endmodule
bind acr_ctrl_status acr_ctrl_status_chk u_chk (.CLOCK, .RSTN, .REG_ADDR, .REG_WR,
    .REG_WDATA, .REG_RD, .REG_RVALID, .GEN1_IRQ, .RELOAD_DONE, .HP_MODE, .HP_CUTOFF,
    .HP_OUT_SEL, .HP_TAP, .HP_GEN1, .HP_GEN2, .FILTER_RESET, .BYTE_ORDER, .RANGE,
    .HIGH_RES, .SPI_3WIRE, .RELOAD_REQ, .REFERENCE, .GEN1_ACTIVE, .GEN1_SRC_CLR,
    .GEN2_IRQ, .GEN2_SRC_CLR);
`default_nettype wire

/* File: acr_host_model.sv */
// host model that drives the register strobes of the bank
`timescale 1ns/10ps
`default_nettype none
module acr_host_model
    import acr_pkg::*;
(
    input  wire logic      CLOCK,      // bank clock
    input  wire logic      REG_RVALID, // read answer
    input  wire acr_byte_t REG_RDATA,  // read data
    output acr_addr_t      REG_ADDR,   // address
    output logic           REG_WR,     // write strobe
    output acr_byte_t      REG_WDATA,  // write data
    output logic           REG_RD      // read strobe
);
    initial begin
        REG_ADDR = 7'h00;
        REG_WR = 1'b0;
        REG_WDATA = 8'h00;
        REG_RD = 1'b0;
    end
    // released lines show the inverse so a stale value is never mistaken for data
    task automatic wr(input acr_addr_t a, input acr_byte_t d);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_WDATA <= (a == 7'h23) ? (d & 8'hf9) : d;
        REG_WR <= 1'b1;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
        REG_ADDR <= ~a;
        REG_WDATA <= ~d;
    endtask
    task automatic rd(input acr_addr_t a, output acr_byte_t d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        REG_ADDR <= ~a;
        for (int n = 0; n < 3 && !ok; n++) begin
            #1;
            ok = (REG_RVALID === 1'b1);
            d = REG_RDATA;
            if (!ok) @(posedge CLOCK);
        end
    endtask
endmodule
`default_nettype wire

/* File: acr_pkg.sv */
// types shared by the accel control/status bank
package acr_pkg;
    typedef enum logic [1:0] {
        ACR_HPM_RESET_ON_REF,
        ACR_HPM_REFERENCE,
        ACR_HPM_NORMAL,
        ACR_HPM_AUTORESET
    } acr_hpm_e;
    typedef logic [7:0] acr_byte_t;
    typedef logic [6:0] acr_addr_t;
endpackage

/* File: acr_regs.svh */
// register offsets, field positions and reset values of the accel control/status bank
//
// Overview of operation
// - filter mode 00 reset-on-reference-read, 01 reference, 10 normal, 11 auto-reset; reset 00
// - two-bit cutoff select sits in bits five and four of filter control
// - filtered-output bit sends filtered samples to output and FIFO; resets 0
// - one bit routes filtered data to tap detection, else bypass
// - two bits apply filter to threshold logic of generator one and two
// - seven enables, reset 0, gate sources onto interrupt pin A
// - block update holds an axis pair until both bytes are read
// - byte order bit: 0 low byte first, 1 high byte first; reset 0
// - range field 00 2g, 01 4g, 10 8g, 11 16g; reset 00
// - high-resolution bit enables high-resolution output; reset 0
// - serial mode bit: 0 four-wire, 1 three-wire; reset 0
// - writing 1 to reboot bit reloads internal memory; reset 0
// - FIFO enable bit turns FIFO on; reset 0
// - latch bit keeps generator request until its source register is read
// - four-direction bit acts only while generator six-direction bit is 1
// - polarity bit: 0 pins active high, 1 active low; reset 0
// - eight-bit reference value, reset zero, feeds interrupts and filtering
// - per-axis and whole-set new-data flags set on fresh samples; reset 0
// - per-axis and whole-set overrun flags set on unread overwrite; reset 0
// - reading generator one source clears its active flag and pin
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

`define ACR_OFS_FILT    7'h21
`define ACR_OFS_PINA    7'h22
`define ACR_OFS_FMT     7'h23
`define ACR_OFS_BOOT    7'h24
`define ACR_OFS_PINB    7'h25
`define ACR_OFS_REF     7'h26
`define ACR_OFS_STAT    7'h27
`define ACR_OFS_OUTX_LO 7'h28
`define ACR_OFS_GEN1SRC 7'h31
`define ACR_OFS_GEN2SRC 7'h35

// writable bit masks; reserved bits read as zero
`define ACR_MSK_PINA    8'hfe
`define ACR_MSK_FMT     8'hf9
`define ACR_MSK_BOOT    8'hcf
`define ACR_MSK_PINB    8'hfa
`define ACR_RST_BYTE    8'h00

`define ACR_BIT_FDS     3
`define ACR_BIT_HPTAP   2
`define ACR_BIT_HPG2    1
`define ACR_BIT_HPG1    0
`define ACR_BIT_BDU     7
`define ACR_BIT_BLE     6
`define ACR_BIT_HR      3
`define ACR_BIT_SIM     0
`define ACR_BIT_REBOOT  7
`define ACR_BIT_FIFOEN  6
`define ACR_BIT_LATCH1  3
`define ACR_BIT_FOURD1  2
`define ACR_BIT_LATCH2  1
`define ACR_BIT_FOURD2  0
`define ACR_BIT_POL     1

`endif

/* File: test_accel_control_status_regs.sv */
// self-checking bench for the accel control and status bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module test_accel_control_status_regs;
    import acr_pkg::*;
    // ----------------------------------------
    // stimulus, model and checks
    // ----------------------------------------
    logic       CLOCK = 1'b0;
    logic       RSTN = 1'b0;
    acr_addr_t  REG_ADDR;
    logic       REG_WR, REG_RD, REG_RVALID, GEN1_ACTIVE, IRQ_PIN_A, IRQ_PIN_B, FOUR_DIR_GEN1;
    logic       GEN2_ACTIVE, FOUR_DIR_GEN2, FIFO_ENABLE;
    acr_byte_t  REG_WDATA, REG_RDATA;
    logic [2:0] smp = 3'h0, AXIS_HOLD;
    logic [7:1] src = 7'h00;
    logic       set_stb = 1'b0, act = 1'b0, six = 1'b0, rdone = 1'b0;
    int         seed = 67341, mismatches = 0, n_checks = 0;
    int         m [8'h21:8'h27];
    int         msk [8'h21:8'h27] = '{8'hff, 8'hfe, 8'hf9, 8'hcf, 8'hfa, 8'hff, 8'h00};
    bit [3:0]   da = 4'h0, ov = 4'h0;
    always #25 CLOCK = ~CLOCK;
    acr_host_model u_host (.CLOCK, .REG_RVALID, .REG_RDATA, .REG_ADDR, .REG_WR, .REG_WDATA,
        .REG_RD);
    acr_ctrl_status u_dut (.CLOCK, .RSTN, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
        .REG_RVALID, .REG_RDATA, .SAMPLE_STB(smp), .SET_STB(set_stb), .TAP_IRQ(src[7]),
        .GEN1_IRQ(src[6]), .GEN2_IRQ(src[5]), .READY1_IRQ(src[4]), .READY2_IRQ(src[3]),
        .WTM_IRQ(src[2]), .FIFO_OVR_IRQ(src[1]), .ACTIVITY(act), .SIX_DIR_GEN1(six),
        .SIX_DIR_GEN2(six), .RELOAD_DONE(rdone), .HP_MODE(), .HP_CUTOFF(), .HP_OUT_SEL(),
        .HP_TAP(), .HP_GEN1(), .HP_GEN2(), .FILTER_RESET(), .AXIS_HOLD, .BYTE_ORDER(),
        .RANGE(), .HIGH_RES(), .SPI_3WIRE(), .RELOAD_REQ(), .FIFO_ENABLE, .FOUR_DIR_GEN1,
        .FOUR_DIR_GEN2, .REFERENCE(), .GEN1_ACTIVE, .GEN2_ACTIVE, .GEN1_SRC_CLR(),
        .GEN2_SRC_CLR(), .IRQ_PIN_A, .IRQ_PIN_B);
    task automatic wrr(input int a, input int d);
        u_host.wr(a[6:0], d[7:0]);
        if (a > 8'h20 && a < 8'h28) m[a] = d & msk[a];
    endtask
    task automatic rdc(input int a, input int e);
        acr_byte_t d;
        logic      ok;
        u_host.rd(a[6:0], d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, e[7:0])
    endtask
    task automatic settle();
        repeat (4) @(posedge CLOCK);
        #1;
    endtask
    task automatic smpl(input logic [2:0] s, input logic st);
        @(posedge CLOCK);
        smp <= s;
        set_stb <= st;
        @(posedge CLOCK);
        smp <= 3'h0;
        set_stb <= 1'b0;
        // an overrun only marks a value that was still unread when replaced
        for (int i = 0; i < 3; i++) if (s[i]) {ov[i], da[i]} = {da[i], 1'b1};
        if (st) {ov[3], da[3]} = {da[3], 1'b1};
    endtask
    task automatic rdax(input int i);
        acr_byte_t d;
        logic      ok;
        u_host.rd(7'(8'h28 + 2 * i), d, ok);
        u_host.rd(7'(8'h29 + 2 * i), d, ok);
        da[i] = 1'b0;
        if (da[2:0] == 3'h0) da[3] = 1'b0;
    endtask
    task automatic route(input int a, input int k, input logic b);
        wrr(a, 1 << k);
        @(posedge CLOCK);
        src <= 7'(1 << (k - 1));
        act <= (k == 3) && b;
        settle();
        `CHK(b ? IRQ_PIN_B : IRQ_PIN_A, 1'b1)
        @(posedge CLOCK);
        src <= 7'h00;
        act <= 1'b0;
        settle();
        `CHK(b ? IRQ_PIN_B : IRQ_PIN_A, 1'b0)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge CLOCK);
        mismatches++;
        summarize();
    end
    initial begin
        acr_byte_t d;
        logic      ok;
        int        a;
        repeat (2) @(posedge CLOCK);
        RSTN <= 1'b1;
        for (a = 8'h21; a < 8'h28; a++) rdc(a, 0);
        rdc(8'h7f, 0);
        wrr(8'h27, 8'hff);
        rdc(8'h27, 0);
        for (int i = 0; i < 24; i++) begin
            a = 8'h21 + (($random(seed) & 32'h7fffffff) % 7);
            wrr(a, $random(seed));
            rdc(a, a == 8'h27 ? {ov, da} : m[a]);
        end
        for (a = 8'h21; a < 8'h27; a++) wrr(a, 0);
        smpl(3'b001, 1'b0);
        rdc(8'h27, {ov, da});
        smpl(3'b111, 1'b1);
        rdc(8'h27, {ov, da});
        smpl(3'b001, 1'b1);
        rdc(8'h27, {ov, da});
        for (int i = 0; i < 3; i++) rdax(i);
        rdc(8'h27, {ov, da});
        wrr(8'h23, 8'h80);
        smpl(3'b001, 1'b0);
        rdc(8'h27, {ov, da});
        u_host.rd(7'h28, d, ok);
        settle();
        `CHK(AXIS_HOLD, 3'b001)
        rdax(0);
        settle();
        `CHK(AXIS_HOLD, 3'b000)
        for (int k = 1; k < 8; k++) route(8'h22, k, 1'b0);
        wrr(8'h22, 8'h00);
        for (int k = 3; k < 8; k++) if (k != 4) route(8'h25, k, 1'b1);
        wrr(8'h25, 8'h02);
        settle();
        `CHK({IRQ_PIN_A, IRQ_PIN_B}, 2'b11)
        wrr(8'h25, 8'h00);
        wrr(8'h21, 8'hc0);
        wrr(8'h24, 8'h0a);
        @(posedge CLOCK);
        src <= 7'h30;
        @(posedge CLOCK);
        src <= 7'h00;
        settle();
        `CHK({GEN1_ACTIVE, GEN2_ACTIVE}, 2'b11)
        u_host.rd(7'h31, d, ok);
        settle();
        `CHK({GEN1_ACTIVE, GEN2_ACTIVE}, 2'b01)
        u_host.rd(7'h35, d, ok);
        settle();
        `CHK(GEN2_ACTIVE, 1'b0)
        wrr(8'h24, 8'h45);
        @(posedge CLOCK);
        six <= 1'b1;
        settle();
        `CHK({FOUR_DIR_GEN1, FOUR_DIR_GEN2, FIFO_ENABLE}, 3'b111)
        @(posedge CLOCK);
        six <= 1'b0;
        settle();
        `CHK({FOUR_DIR_GEN1, FOUR_DIR_GEN2, FIFO_ENABLE}, 3'b001)
        wrr(8'h25, 8'h10);
        wrr(8'h24, 8'h80);
        settle();
        `CHK(IRQ_PIN_B, 1'b1)
        @(posedge CLOCK);
        rdone <= 1'b1;
        @(posedge CLOCK);
        rdone <= 1'b0;
        settle();
        `CHK(IRQ_PIN_B, 1'b0)
        rdc(8'h24, 0);
        summarize();
    end
endmodule
`default_nettype wire
